//--- timer8_channel.v
// One channel of the dual 8-bit timer with a classic Wishbone register slave
`timescale 1ns/100ps
`include "timer8_map.vh"

////////////////////////////////////////////////////////////////////////////////
module timer8_channel #(
  parameter CHANNEL = 0                     // 0 or 1: selects the divisor set
) (
  input  wire       clk_i,                  // System clock, 125 MHz
  input  wire       reset_n_i,              // Asynchronous reset, active low
  input  wire       standby_i,              // Standby entry, reinitialises timer
  input  wire       cyc_i,                  // Wishbone cycle
  input  wire       stb_i,                  // Wishbone strobe
  input  wire       we_i,                   // Wishbone write enable
  input  wire [4:0] adr_i,                  // Byte address; bit 4 picks page
  input  wire [3:0] sel_i,                  // Byte lane selects
  input  wire [31:0] dat_i,                 // Write data
  output reg  [31:0] dat_o,                 // Read data
  output reg        ack_o,                  // Wishbone acknowledge
  input  wire       external_count_pin_i,   // External count clock pin
  input  wire       external_clear_pin_i,   // External counter clear pin
  output reg        timer_output_pin_o,     // Compare-match output level
  output wire       timer_output_en_o,      // Output enable of the timer pin
  output wire       match_a_irq_o,          // Match-A request
  output wire       match_b_irq_o,          // Match-B request
  output wire       wrap_irq_o              // Wrap request
);

  ////////////////////////////////////////////////////////////////////////////////
  reg  [7:0]  timer_control_q;
  reg  [7:0]  flags_q;
  reg  [7:0]  constant_a_q;
  reg  [7:0]  constant_b_q;
  reg  [7:0]  count_value_q;
  reg  [7:0]  shared_q;
  reg  [2:0]  read_seen_q;
  reg  [`PRESCALE_WIDTH-1:0] prescale_q;
  reg  [1:0]  cnt_sync_q;
  reg  [1:0]  clr_sync_q;
  reg         cnt_last_q;
  reg         clr_last_q;
  reg         tap_last_q;

  wire [2:0]  clock_select = timer_control_q[2:0];
  wire [1:0]  clear_mode   = timer_control_q[4:3];
  wire        internal_divider_select_ch0 = shared_q[0];
  wire        internal_divider_select_ch1 = shared_q[1];
  wire        alt_div = (CHANNEL == 0) ? internal_divider_select_ch0
                                       : internal_divider_select_ch1;
  wire        access    = cyc_i & stb_i & ~ack_o;
  wire        wr        = access & we_i & sel_i[0];
  wire        rd        = access & ~we_i;
  wire        page      = adr_i[4];
  wire [3:0]  reg_ofs   = {adr_i[3:2], 2'b00};

  ////////////////////////////////////////////////////////////////////////////////
  // Prescaler tap picks the divided clock; counting on its falling edge
  function tap_of;
    input [`PRESCALE_WIDTH-1:0] p;
    input [1:0] sel;
    input       alt;
    input       ch;
    begin
      case (sel)
        2'h1:    tap_of = alt ? p[0] : p[2];
        2'h2:    tap_of = alt ? (ch ? p[6] : p[4]) : p[5];
        2'h3:    tap_of = alt ? (ch ? p[10] : p[7]) : p[9];
        default: tap_of = 1'b0;
      endcase
    end
  endfunction

  wire tap_now  = clock_select[2] ? 1'b0 : tap_of(prescale_q, clock_select[1:0], alt_div,
                                                 CHANNEL != 0);
  // Switching sources while old tap high and new low counts one step, as silicon does
  wire int_tick = ~clock_select[2] & (clock_select[1:0] != 2'h0) & tap_last_q & ~tap_now;
  wire cnt_rise = cnt_sync_q[1] & ~cnt_last_q;
  wire cnt_fall = ~cnt_sync_q[1] & cnt_last_q;
  reg  ext_tick;
  always @* begin
    case (clock_select)
      `CKS_EXT_RISE: ext_tick = cnt_rise;
      `CKS_EXT_FALL: ext_tick = cnt_fall;
      `CKS_EXT_BOTH: ext_tick = cnt_rise | cnt_fall;
      default:       ext_tick = 1'b0;
    endcase
  end
  wire tick = int_tick | ext_tick;

  ////////////////////////////////////////////////////////////////////////////////
  // Match is signalled in the last cycle of the value, just as the count moves on
  wire eq_a    = (count_value_q == constant_a_q);
  wire eq_b    = (count_value_q == constant_b_q);
  wire wr_tim  = wr & (page == `PAGE_TIMER);
  wire wr_ca   = wr_tim & (reg_ofs == `OFS_CONST_A);
  wire wr_cb   = wr_tim & (reg_ofs == `OFS_CONST_B);
  wire wr_cnt  = wr & (page == `PAGE_SHARED) & (reg_ofs == `OFS_COUNT);
  wire match_a = tick & eq_a & ~wr_ca;
  wire match_b = tick & eq_b & ~wr_cb;
  wire clr_pin = clr_sync_q[1] & ~clr_last_q;
  reg  clear_now;
  always @* begin
    case (clear_mode)
      `CLR_MATCH_A: clear_now = match_a;
      `CLR_MATCH_B: clear_now = match_b;
      `CLR_EXT_PIN: clear_now = clr_pin;
      default:      clear_now = 1'b0;
    endcase
  end
  wire wrap = tick & ~clear_now & ~wr_cnt & (count_value_q == 8'hFF);

  ////////////////////////////////////////////////////////////////////////////////
  // Output action resolution, toggle over high over low
  wire [1:0] act_a = match_a ? flags_q[1:0] : `ACT_NONE;
  wire [1:0] act_b = match_b ? flags_q[3:2] : `ACT_NONE;
  // True when either match asks for the given output action
  function wants;
    input [1:0] a;
    input [1:0] b;
    input [1:0] code;
    begin
      wants = (a == code) | (b == code);
    end
  endfunction

  reg        out_d;
  always @* begin
    if (wants(act_a, act_b, `ACT_TOGGLE))
      out_d = ~timer_output_pin_o;
    else if (wants(act_a, act_b, `ACT_HIGH))
      out_d = 1'b1;
    else if (wants(act_a, act_b, `ACT_LOW))
      out_d = 1'b0;
    else
      out_d = timer_output_pin_o;
  end
  assign timer_output_en_o = (flags_q[3:0] != 4'h0);

  assign match_a_irq_o = flags_q[`BIT_MATCH_A] & timer_control_q[6];
  assign match_b_irq_o = flags_q[`BIT_MATCH_B] & timer_control_q[7];
  assign wrap_irq_o    = flags_q[`BIT_WRAP]    & timer_control_q[5];

  ////////////////////////////////////////////////////////////////////////////////
  // Synchronisers and edge history; pins idle low so no false edge after reset
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_sync_q <= 2'b00;
      clr_sync_q <= 2'b00;
      cnt_last_q <= 1'b0;
      clr_last_q <= 1'b0;
    end else begin
      cnt_sync_q <= {cnt_sync_q[0], external_count_pin_i};
      clr_sync_q <= {clr_sync_q[0], external_clear_pin_i};
      cnt_last_q <= cnt_sync_q[1];
      clr_last_q <= clr_sync_q[1];
    end
  end

  // Free-running prescaler; every internal rate is a tap of it
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      prescale_q <= {`PRESCALE_WIDTH{1'b0}};
      tap_last_q <= 1'b0;
    end else begin
      prescale_q <= prescale_q + {{(`PRESCALE_WIDTH-1){1'b0}}, 1'b1};
      tap_last_q <= tap_now;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Counter, flags, output and software registers
  wire [7:0] wdat   = dat_i[7:0];
  wire       rd_fl  = rd & (page == `PAGE_TIMER) & (reg_ofs == `OFS_FLAGS);
  wire [2:0] clr_fl = (wr_tim & (reg_ofs == `OFS_FLAGS)) ?
                      (read_seen_q & ~wdat[7:5]) : 3'b000;
  wire [2:0] set_fl = {match_b, match_a, wrap};

  // Count value: clear beats write, write beats step
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      count_value_q <= `RST_COUNT;
    end else if (standby_i) begin
      count_value_q <= `RST_COUNT;
    end else if (clear_now) begin
      count_value_q <= 8'h00;
    end else if (wr_cnt) begin
      count_value_q <= wdat;
    end else if (tick) begin
      count_value_q <= count_value_q + 8'h01;
    end
  end

  // Flags: hardware set wins over a same-cycle software clear
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      flags_q     <= `RST_FLAGS;
      read_seen_q <= 3'b000;
    end else if (standby_i) begin
      flags_q     <= `RST_FLAGS;
      read_seen_q <= 3'b000;
    end else begin
      flags_q[7:5] <= (flags_q[7:5] & ~clr_fl) | set_fl;
      flags_q[`BIT_RESERVED] <= 1'b1;
      if (wr_tim & (reg_ofs == `OFS_FLAGS))
        flags_q[3:0] <= wdat[3:0];
      // Read arms the clear only for bits seen as one
      if (rd_fl)
        read_seen_q <= flags_q[7:5];
      else
        read_seen_q <= read_seen_q & ~clr_fl;
    end
  end

  // Control and constants; the shared register survives standby
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      timer_control_q <= `RST_CONTROL;
      constant_a_q    <= `RST_CONST;
      constant_b_q    <= `RST_CONST;
      shared_q        <= `RST_SHARED;
    end else if (standby_i) begin
      timer_control_q <= `RST_CONTROL;
      constant_a_q    <= `RST_CONST;
      constant_b_q    <= `RST_CONST;
    end else begin
      if (wr_tim & (reg_ofs == `OFS_CONTROL))
        timer_control_q <= wdat;
      if (wr_ca)
        constant_a_q <= wdat;
      if (wr_cb)
        constant_b_q <= wdat;
      if (wr & (page == `PAGE_SHARED) & (reg_ofs == `OFS_SHARED))
        shared_q <= wdat;
    end
  end

  // Pin keeps its level through standby; only reset forces it low
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i)
      timer_output_pin_o <= 1'b0;
    else if (!standby_i)
      timer_output_pin_o <= out_d;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Wishbone answer one cycle after the request; unmapped reads return zero
  // Only lane 0 writes; other lanes are acknowledged and dropped
  reg [7:0] rd_byte;
  always @* begin
    rd_byte = 8'h00;
    if (page == `PAGE_TIMER) begin
      case (reg_ofs)
        `OFS_CONTROL: rd_byte = timer_control_q;
        `OFS_FLAGS:   rd_byte = flags_q;
        `OFS_CONST_A: rd_byte = constant_a_q;
        `OFS_CONST_B: rd_byte = constant_b_q;
        default:      rd_byte = 8'h00;
      endcase
    end else begin
      case (reg_ofs)
        `OFS_COUNT:  rd_byte = count_value_q;
        `OFS_SHARED: rd_byte = shared_q;
        default:     rd_byte = 8'h00;
      endcase
    end
  end

  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= access;
      if (rd)
        dat_o <= {24'h000000, rd_byte};
    end
  end

endmodule

//--- timer8_map.vh
// Register offsets, field positions and reset values of the 8-bit timer channel
`ifndef TIMER8_MAP_VH
`define TIMER8_MAP_VH
`define OFS_CONTROL      4'h0
`define OFS_FLAGS        4'h4
`define OFS_CONST_A      4'h8
`define OFS_CONST_B      4'hC
`define OFS_COUNT        4'h0
`define OFS_SHARED       4'h4
`define PAGE_TIMER       1'b0
`define PAGE_SHARED      1'b1
`define RST_CONTROL      8'h00
`define RST_FLAGS        8'h10
`define RST_CONST        8'hFF
`define RST_COUNT        8'h00
`define RST_SHARED       8'h00
`define BIT_MATCH_B      7
`define BIT_MATCH_A      6
`define BIT_WRAP         5
`define BIT_RESERVED     4
`define CKS_STOP0        3'h0
`define CKS_STOP1        3'h4
`define CKS_EXT_RISE     3'h5
`define CKS_EXT_FALL     3'h6
`define CKS_EXT_BOTH     3'h7
`define CLR_NONE         2'h0
`define CLR_MATCH_A      2'h1
`define CLR_MATCH_B      2'h2
`define CLR_EXT_PIN      2'h3
`define ACT_NONE         2'h0
`define ACT_LOW          2'h1
`define ACT_HIGH         2'h2
`define ACT_TOGGLE       2'h3
`define PRESCALE_WIDTH   11
`endif

//--- timer8_channel_assertions.sv
// Port checker for one 8-bit timer channel
`timescale 1ns/100ps
module timer8_channel_checker (
  input wire logic        clk_i,              // Clock
  input wire logic        reset_n_i,          // Reset
  input wire logic        standby_i,          // Standby
  input wire logic        cyc_i,              // Cycle
  input wire logic        stb_i,              // Strobe
  input wire logic        we_i,               // Write
  input wire logic [4:0]  adr_i,              // Address
  input wire logic [3:0]  sel_i,              // Lanes
  input wire logic [31:0] dat_i,              // Write data
  input wire logic [31:0] dat_o,              // Read data
  input wire logic        ack_o,              // Ack
  input wire logic        timer_output_pin_o, // Pin
  input wire logic        timer_output_en_o,  // Pin enable
  input wire logic        match_a_irq_o,      // Irq A
  input wire logic        match_b_irq_o,      // Irq B
  input wire logic        wrap_irq_o          // Irq wrap
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  logic [3:0] os_q;
  wire        req_taken = cyc_i && stb_i && !ack_o;
  // Shadow of the output-select field as software last wrote it
  always_ff @(posedge clk_i or negedge reset_n_i)
    if (!reset_n_i) os_q <= 4'h0;
    else if (standby_i) os_q <= 4'h0;
    else if (req_taken && we_i && sel_i[0] && adr_i == 5'h04) os_q <= dat_i[3:0];
  sequence flags_read;
    req_taken && !we_i && adr_i == 5'h04;
  endsequence
  sequence quiet_irqs;
    !match_a_irq_o && !match_b_irq_o && !wrap_irq_o;
  endsequence
  chk_ack_follows: assert property (req_taken |=> ack_o) else $error("ack missing");
  chk_ack_single: assert property (ack_o |=> !ack_o) else $error("ack too long");
  chk_reserved_one: assert property (flags_read |=> dat_o[4]) else $error("bit 4 low");
  chk_out_enable: assert property (timer_output_en_o == (os_q != 4'h0))
    else $error("enable wrong");
  chk_pin_hold: assert property ((os_q == 4'h0)[*2] |-> $stable(timer_output_pin_o))
    else $error("pin moved");
  chk_reset_quiet: assert property ($rose(reset_n_i) |-> !timer_output_pin_o ##0 quiet_irqs)
    else $error("not quiet after reset");
  chk_standby_quiet: assert property (standby_i |=> quiet_irqs and !timer_output_en_o)
    else $error("standby not applied");
  chk_wrap_clear: assert property ($fell(wrap_irq_o) |-> $past(req_taken && we_i))
    else $error("wrap irq fell unasked");
  chk_a_clear: assert property ($fell(match_a_irq_o) |-> $past(req_taken && we_i))
    else $error("irq a fell unasked");
endmodule
bind timer8_channel timer8_channel_checker chk_u (.clk_i(clk_i), .reset_n_i(reset_n_i),
  .standby_i(standby_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
  .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
  .timer_output_pin_o(timer_output_pin_o), .timer_output_en_o(timer_output_en_o),
  .match_a_irq_o(match_a_irq_o), .match_b_irq_o(match_b_irq_o), .wrap_irq_o(wrap_irq_o));

//--- ext_pins_model.sv
// Model of the external count and clear pins
`timescale 1ns/100ps
module ext_pins_model (
  input  wire logic clk_i,       // System clock
  output logic      count_pin_o, // Count pin
  output logic      clear_pin_o  // Clear pin
);
  initial count_pin_o = 1'b0;
  initial clear_pin_o = 1'b0;
  // Levels of four cycles or more so the synchroniser never misses an edge
  task automatic pulse_count(input int n);
    repeat (n) begin
      @(posedge clk_i) count_pin_o <= 1'b1;
      repeat (4) @(posedge clk_i);
      count_pin_o <= 1'b0;
      repeat (4) @(posedge clk_i);
    end
  endtask
  task automatic pulse_clear();
    @(posedge clk_i) clear_pin_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    clear_pin_o <= 1'b0;
  endtask
endmodule

//--- tb_top.sv
// Self-checking bench for one 8-bit timer channel
`timescale 1ns/100ps
module tb_top;
  logic        clk_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic        standby_i = 1'b0;
  logic        cyc_i = 1'b0;
  logic        stb_i = 1'b0;
  logic        we_i = 1'b0;
  logic [4:0]  adr_i = 5'h00;
  logic [3:0]  sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o, rd;
  logic        ack_o, pin_o, en_o, irq_a_o, irq_b_o, irq_w_o, cnt_pin, clr_pin;
  int          bad_count = 0;
  int          checked = 0;
  timer8_channel #(.CHANNEL(0)) dut_u (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .standby_i(standby_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .external_count_pin_i(cnt_pin), .external_clear_pin_i(clr_pin),
    .timer_output_pin_o(pin_o), .timer_output_en_o(en_o), .match_a_irq_o(irq_a_o),
    .match_b_irq_o(irq_b_o), .wrap_irq_o(irq_w_o));
  ext_pins_model pins_u (.clk_i(clk_i), .count_pin_o(cnt_pin), .clear_pin_o(clr_pin));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    {cyc_i, stb_i, we_i} <= {2'b11, w};
    adr_i <= a;
    sel_i <= 4'h1;
    dat_i <= {24'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 40);
    if (n >= 40) bad_count++;
    rd = dat_o;
    {cyc_i, stb_i, we_i} <= 3'b000;
  endtask
  task automatic cmp(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask
  task automatic rdchk(input logic [4:0] a, input logic [31:0] exp);
    bus(1'b0, a, 8'h00);
    cmp($sformatf("register %h", a), exp, rd);
  endtask
  task automatic wait_sync();
    repeat (8) @(posedge clk_i);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic reset_values();
    rdchk(5'h00, 32'h00);
    rdchk(5'h04, 32'h10);
    rdchk(5'h08, 32'hFF);
    rdchk(5'h0C, 32'hFF);
    rdchk(5'h10, 32'h00);
    rdchk(5'h14, 32'h00);
    bus(1'b1, 5'h18, 8'hFF);
    rdchk(5'h18, 32'h00);
  endtask
  task automatic match_and_clear();
    bus(1'b1, 5'h08, 8'h02);
    bus(1'b1, 5'h0C, 8'h02);
    bus(1'b1, 5'h04, 8'h07);
    bus(1'b1, 5'h00, 8'hC5);
    pins_u.pulse_count(3);
    wait_sync();
    rdchk(5'h10, 32'h03);
    rdchk(5'h04, 32'hD7);
    cmp("pin", 32'h1, {31'h0, pin_o});
    cmp("irq a", 32'h1, {31'h0, irq_a_o});
    cmp("irq b", 32'h1, {31'h0, irq_b_o});
    cmp("enable", 32'h1, {31'h0, en_o});
    bus(1'b1, 5'h04, 8'hF7);
    rdchk(5'h04, 32'hD7);
    bus(1'b1, 5'h04, 8'h17);
    rdchk(5'h04, 32'h17);
  endtask
  task automatic wrap_flag();
    bus(1'b1, 5'h10, 8'hFE);
    bus(1'b1, 5'h00, 8'h25);
    pins_u.pulse_count(2);
    wait_sync();
    rdchk(5'h04, 32'h37);
    cmp("wrap irq", 32'h1, {31'h0, irq_w_o});
    bus(1'b1, 5'h04, 8'h17);
    cmp("wrap irq", 32'h0, {31'h0, irq_w_o});
  endtask
  task automatic ext_modes();
    logic [7:0] exp [4] = '{8'h00, 8'h02, 8'h02, 8'h04};
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, 5'h10, 8'h00);
      bus(1'b1, 5'h00, 8'h04 + 8'(i));
      pins_u.pulse_count(2);
      wait_sync();
      rdchk(5'h10, {24'h0, exp[i]});
    end
    bus(1'b1, 5'h00, 8'h1D);
    pins_u.pulse_clear();
    wait_sync();
    rdchk(5'h10, 32'h00);
  endtask
  task automatic internal_and_stop();
    logic [31:0] first;
    bus(1'b1, 5'h14, 8'h01);
    bus(1'b1, 5'h00, 8'h01);
    repeat (40) @(posedge clk_i);
    bus(1'b1, 5'h00, 8'h00);
    bus(1'b0, 5'h10, 8'h00);
    first = rd;
    cmp("count by two", 32'h1, {31'h0, first >= 32'd18 && first <= 32'd24});
    repeat (20) @(posedge clk_i);
    rdchk(5'h10, first);
  endtask
  task automatic standby_init();
    @(posedge clk_i);
    standby_i <= 1'b1;
    @(posedge clk_i);
    standby_i <= 1'b0;
    rdchk(5'h04, 32'h10);
    rdchk(5'h08, 32'hFF);
    rdchk(5'h14, 32'h01);
    cmp("enable", 32'h0, {31'h0, en_o});
  endtask
  task automatic conclude();
    $display("checks %0d, mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #4 clk_i = ~clk_i;
  end
  initial begin
    repeat (5) @(posedge clk_i);
    reset_n_i <= 1'b1;
    reset_values();
    match_and_clear();
    wrap_flag();
    ext_modes();
    internal_and_stop();
    standby_init();
    conclude();
  end
  initial begin
    #200000;
    bad_count++;
    conclude();
  end
endmodule
